// file: src/aic_pkg.sv
// Constants and types shared by the analog input scaling curve block
package aic_pkg;

  // ==========================================================
  // Sizes
  localparam int NCURVE = 10;
  localparam int MAXPT = 20;
  localparam int NSRC = 16;
  localparam int SRC_W = 4;
  localparam int VAL_W = 40;
  localparam int NUM_W = 96;
  localparam int ADDR_W = 12;
  localparam int PT_IDX_W = 8;
  localparam int TAU_W = 20;
  localparam int UPD_W = 11;
  localparam int USED_W = MAXPT - 2;

  // ==========================================================
  // Value format: signed, one lsb is 0.00001
  localparam logic signed [VAL_W-1:0] SCALE = 40'sh00000186a0;
  localparam logic signed [VAL_W-1:0] HALF = 40'sh000000c350;

  // ==========================================================
  // Timing
  localparam int CLK_HZ = 200_000_000;
  localparam int STEP_TIME_MS = 5;
  localparam int TICK_CYC = CLK_HZ / 1000 * STEP_TIME_MS;
  localparam int TAU_DEF_MS = 1000;
  localparam int UPD_DEF_MS = 150;
  localparam logic [TAU_W-1:0] TAU_DEF = TAU_W'(TAU_DEF_MS / STEP_TIME_MS);
  localparam logic [UPD_W-1:0] UPD_DEF = UPD_W'(UPD_DEF_MS / STEP_TIME_MS);

  // ==========================================================
  // Register map
  localparam logic [3:0] GLB_PAGE = 4'h0;
  localparam logic [3:0] CRV_PAGE = 4'h1;
  localparam int PT_FLAG_BIT = 11;
  localparam logic [ADDR_W-1:0] A_GLOBAL = 12'h000;
  localparam logic [ADDR_W-1:0] A_IRQ_ST = 12'h001;
  localparam logic [ADDR_W-1:0] A_IRQ_MASK = 12'h002;
  localparam logic [ADDR_W-1:0] A_FLAGS = 12'h003;
  localparam logic [3:0] F_CTRL = 4'h0;
  localparam logic [3:0] F_TAU = 4'h1;
  localparam logic [3:0] F_UPD = 4'h2;
  localparam logic [3:0] F_MIN = 4'h3;
  localparam logic [3:0] F_MAX = 4'h4;
  localparam logic [3:0] F_INPUT = 4'h5;
  localparam logic [3:0] F_OUTPUT = 4'h6;
  localparam logic [3:0] F_USED = 4'h7;
  localparam int GLB_EN_BIT = 0;
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_FILT_BIT = 1;
  localparam int CTRL_RNG_BIT = 2;
  localparam int CTRL_RND_LSB = 4;
  localparam int CTRL_SRC_LSB = 8;

  // ==========================================================
  // Types
  typedef enum logic [1:0] {
    RND_FLOAT = 2'b00,
    RND_FLOOR = 2'b01,
    RND_CEIL = 2'b10,
    RND_NEAREST = 2'b11
  } aic_round_e;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_FDIV = 3'b001,
    S_SCAN = 3'b010,
    S_CHK = 3'b011,
    S_IDIV = 3'b100,
    S_DONE = 3'b101
  } aic_state_e;

endpackage

// file: src/aic_point_mem.sv
// Curve point store with reset defaults and registered read
`timescale 1ns/100ps
module aic_point_mem
#(
  parameter int DEPTH = 200,
  parameter int WIDTH = 40,
  parameter int IDX_W = 8,
  parameter int INIT_STRIDE = 20,
  parameter int INIT_IDX = 1,
  parameter logic [WIDTH-1:0] INIT_VAL = '0
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Write port
  input wire logic we_i,
  input wire logic [IDX_W-1:0] waddr_i,
  input wire logic [WIDTH-1:0] wdata_i,
  // Read port
  input wire logic [IDX_W-1:0] raddr_i,
  output logic [WIDTH-1:0] rdata_o
);

  logic [WIDTH-1:0] mem [DEPTH];

  // ==========================================================
  // Storage
  for (genvar i = 0; i < DEPTH; i++)
  begin : g_ent
    always_ff @(posedge clk_i or posedge reset_i)
    begin
      if (reset_i)
        mem[i] <= ((i % INIT_STRIDE) == INIT_IDX) ? INIT_VAL : '0;
      else if (we_i && waddr_i == IDX_W'(i))
        mem[i] <= wdata_i;
    end
  end

  // ==========================================================
  // Read
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      rdata_o <= '0;
    else if (raddr_i < IDX_W'(DEPTH))
      rdata_o <= mem[raddr_i];
    else
      rdata_o <= '0;
  end

endmodule

// file: src/aic_divider.sv
// Serial signed divider, quotient truncated toward zero
`timescale 1ns/100ps
module aic_divider
#(
  parameter int NUM_W = 96,
  parameter int DEN_W = 40
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Request
  input wire logic start_i,
  input wire logic signed [NUM_W-1:0] num_i,
  input wire logic signed [DEN_W-1:0] den_i,
  // Answer
  output logic done_o,
  output logic signed [NUM_W-1:0] quot_o
);

  logic busy;
  logic neg;
  logic [6:0] cnt;
  logic [NUM_W-1:0] q;
  logic [DEN_W:0] rem;
  logic [DEN_W:0] dv;
  logic [DEN_W:0] trial;
  logic ge;
  logic [NUM_W-1:0] next_q;

  assign trial = {rem[DEN_W-1:0], q[NUM_W-1]};
  assign ge = trial >= dv;
  assign next_q = {q[NUM_W-2:0], ge};

  // ==========================================================
  // Shift and subtract
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      busy <= 1'b0;
      neg <= 1'b0;
      cnt <= '0;
      q <= '0;
      rem <= '0;
      dv <= '0;
      done_o <= 1'b0;
      quot_o <= '0;
    end
    else
    begin
      done_o <= 1'b0;
      if (start_i && !busy)
      begin
        busy <= 1'b1;
        neg <= num_i[NUM_W-1] ^ den_i[DEN_W-1];
        cnt <= 7'(NUM_W - 1);
        q <= num_i[NUM_W-1] ? NUM_W'(-num_i) : NUM_W'(num_i);
        rem <= '0;
        dv <= {1'b0, den_i[DEN_W-1] ? DEN_W'(-den_i) : DEN_W'(den_i)};
      end
      else if (busy)
      begin
        q <= next_q;
        rem <= ge ? trial - dv : trial;
        cnt <= cnt - 7'h01;
        if (cnt == 7'h00)
        begin
          busy <= 1'b0;
          done_o <= 1'b1;
          quot_o <= neg ? -signed'(next_q) : signed'(next_q);
        end
      end
    end
  end

endmodule

// file: src/aic_scaling_curves.sv
// Ten analog input scaling curves with filter, range flag and rounding
//
// Functional notes
// - Global scaling enable, off by default, gates processing
// - Ten curves, each enabled separately, default off
// - Per-curve source select, default first mA input
// - Optional first-order filter, tau 5 ms steps
// - Range flag produced only when range check on
// - Flag set below minimum or above maximum
// - Signed limits in 0.00001 units, default zero
// - Lost signal holds last valid measured value
// - Update cycle in 5 ms steps, default 150 ms
// - Output float, floor, ceiling or nearest integer
// - Two fixed points, defaults input 0 and 1
// - Points three to twenty switchable, default unused
// - Input and scaled output readable per curve
//
// Decided for this implementation: strobed register access and the address map.
`timescale 1ns/100ps
module aic_scaling_curves
  import aic_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
)
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [VAL_W-1:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  output logic [VAL_W-1:0] rdata_o,
  // Measurement channels
  input wire logic signed [VAL_W-1:0] meas_i [NSRC],
  input wire logic [NSRC-1:0] meas_valid_i,
  // Indications
  output logic [NCURVE-1:0] scaling_curve_range_flag_o,
  output logic irq_o
);

  // ==========================================================
  // Declarations
  logic glb_en;
  logic [NCURVE-1:0] irq_st;
  logic [NCURVE-1:0] irq_mask;
  logic [NCURVE-1:0] flag_prev;
  logic [NCURVE-1:0] en, filt_en, rng_en, pending;
  logic [1:0] rnd [NCURVE];
  logic [SRC_W-1:0] src [NCURVE];
  logic [TAU_W-1:0] tau [NCURVE];
  logic [UPD_W-1:0] upd [NCURVE];
  logic [UPD_W-1:0] timer [NCURVE];
  logic [USED_W-1:0] used [NCURVE];
  logic signed [VAL_W-1:0] lim_min [NCURVE];
  logic signed [VAL_W-1:0] lim_max [NCURVE];
  logic signed [VAL_W-1:0] in_val [NCURVE];
  logic signed [VAL_W-1:0] out_val [NCURVE];
  logic signed [VAL_W-1:0] raw_last [NCURVE];
  logic [NCURVE-1:0] flag, have;
  logic [31:0] tick_cnt;
  logic tick;
  logic glb_hit, crv_hit, pt_hit, crv_we;
  logic [3:0] bc;
  logic [PT_IDX_W-1:0] bus_idx, eng_idx, mem_raddr;
  logic signed [VAL_W-1:0] in_q, out_q;
  logic rd_mem_q, rd_sel_q;
  logic [VAL_W-1:0] reg_rd, reg_rdata_q;
  aic_state_e state;
  logic [3:0] cur, pick;
  logic pick_ok;
  logic [4:0] pt;
  logic pt_used, eng_rd_ok, prev_ok;
  logic signed [VAL_W-1:0] cur_y, px, py, result, x_new;
  logic div_start, div_done;
  logic signed [NUM_W-1:0] div_num, div_q;
  logic signed [VAL_W-1:0] div_den;

  function automatic logic signed [NUM_W-1:0] ext(
    input logic signed [VAL_W-1:0] v);
    ext = {{(NUM_W-VAL_W){v[VAL_W-1]}}, v};
  endfunction

  function automatic logic signed [VAL_W-1:0] round_val(
    input logic signed [VAL_W-1:0] v, input logic [1:0] m);
    logic signed [VAL_W-1:0] r;
    logic signed [VAL_W-1:0] f;
    logic signed [VAL_W-1:0] h;
    r = v % SCALE;
    f = (r < 0) ? v - r - SCALE : v - r;
    h = v + HALF;
    case (m)
      RND_FLOOR: round_val = f;
      RND_CEIL: round_val = (r == 0) ? v : f + SCALE;
      RND_NEAREST:
      begin
        r = h % SCALE;
        round_val = (r < 0) ? h - r - SCALE : h - r;
      end
      default: round_val = v;
    endcase
  endfunction

  // ==========================================================
  // Address decode
  assign bc = addr_i[7:4];
  assign glb_hit = !addr_i[PT_FLAG_BIT] && addr_i[11:8] == GLB_PAGE;
  assign crv_hit = addr_i[11:8] == CRV_PAGE && bc < 4'(NCURVE);
  assign pt_hit = addr_i[PT_FLAG_BIT] && addr_i[10:6] < 5'(NCURVE)
                  && addr_i[5:1] < 5'(MAXPT);
  assign crv_we = we_i && crv_hit;
  assign bus_idx = PT_IDX_W'(addr_i[10:6]) * PT_IDX_W'(MAXPT)
                   + PT_IDX_W'(addr_i[5:1]);
  assign eng_idx = PT_IDX_W'(cur) * PT_IDX_W'(MAXPT) + PT_IDX_W'(pt);
  assign eng_rd_ok = !(re_i && pt_hit);
  assign mem_raddr = eng_rd_ok ? eng_idx : bus_idx;

  // ==========================================================
  // Global, mask and status registers
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      glb_en <= 1'b0;
      irq_mask <= '0;
    end
    else if (we_i && glb_hit && addr_i == A_GLOBAL)
      glb_en <= wdata_i[GLB_EN_BIT];
    else if (we_i && glb_hit && addr_i == A_IRQ_MASK)
      irq_mask <= wdata_i[NCURVE-1:0];
  end

  // Set wins over write-one-clear
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      irq_st <= '0;
      flag_prev <= '0;
    end
    else
    begin
      flag_prev <= scaling_curve_range_flag_o;
      irq_st <= (irq_st & ~((we_i && glb_hit && addr_i == A_IRQ_ST)
                ? wdata_i[NCURVE-1:0] : '0))
                | (scaling_curve_range_flag_o & ~flag_prev);
    end
  end

  assign irq_o = |(irq_st & irq_mask);

  // ==========================================================
  // 5 ms step tick
  assign tick = tick_cnt == 32'(TICK_CYCLES - 1);

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
      tick_cnt <= '0;
    else
      tick_cnt <= tick ? '0 : tick_cnt + 32'h1;
  end

  // ==========================================================
  // Per-curve settings and update timer
  for (genvar g = 0; g < NCURVE; g++)
  begin : g_crv
    always_ff @(posedge clk_i or posedge reset_i)
    begin
      if (reset_i)
      begin
        en[g] <= 1'b0;
        filt_en[g] <= 1'b0;
        rng_en[g] <= 1'b0;
        rnd[g] <= RND_FLOAT;
        src[g] <= '0;
        tau[g] <= TAU_DEF;
        upd[g] <= UPD_DEF;
        lim_min[g] <= '0;
        lim_max[g] <= '0;
        used[g] <= '0;
      end
      else if (crv_we && bc == 4'(g))
      begin
        case (addr_i[3:0])
          F_CTRL:
          begin
            en[g] <= wdata_i[CTRL_EN_BIT];
            filt_en[g] <= wdata_i[CTRL_FILT_BIT];
            rng_en[g] <= wdata_i[CTRL_RNG_BIT];
            rnd[g] <= wdata_i[CTRL_RND_LSB +: 2];
            src[g] <= wdata_i[CTRL_SRC_LSB +: SRC_W];
          end
          F_TAU: tau[g] <= (wdata_i[TAU_W-1:0] == '0) ? TAU_W'(1)
                           : wdata_i[TAU_W-1:0];
          F_UPD: upd[g] <= (wdata_i[UPD_W-1:0] == '0) ? UPD_W'(1)
                           : wdata_i[UPD_W-1:0];
          F_MIN: lim_min[g] <= wdata_i;
          F_MAX: lim_max[g] <= wdata_i;
          F_USED: used[g] <= wdata_i[USED_W-1:0];
          default: ;
        endcase
      end
    end

    // Pending set wins over the engine's clear
    always_ff @(posedge clk_i or posedge reset_i)
    begin
      if (reset_i)
      begin
        timer[g] <= '0;
        pending[g] <= 1'b0;
      end
      else if (!(glb_en && en[g]))
      begin
        timer[g] <= upd[g] - UPD_W'(1);
        pending[g] <= 1'b0;
      end
      else
      begin
        if (tick)
          timer[g] <= (timer[g] == '0) ? upd[g] - UPD_W'(1)
                      : timer[g] - UPD_W'(1);
        pending[g] <= (tick && timer[g] == '0)
                      || (pending[g] && !(state == S_DONE && cur == 4'(g)));
      end
    end

    assign scaling_curve_range_flag_o[g] = flag[g] && rng_en[g]
                                           && en[g] && glb_en;
  end

  // ==========================================================
  // Point memories
  aic_point_mem #(.DEPTH(NCURVE * MAXPT), .WIDTH(VAL_W), .IDX_W(PT_IDX_W),
    .INIT_STRIDE(MAXPT), .INIT_IDX(1), .INIT_VAL(SCALE)) u_in_mem (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .we_i(we_i && pt_hit && !addr_i[0]),
    .waddr_i(bus_idx),
    .wdata_i(wdata_i),
    .raddr_i(mem_raddr),
    .rdata_o(in_q)
  );

  aic_point_mem #(.DEPTH(NCURVE * MAXPT), .WIDTH(VAL_W), .IDX_W(PT_IDX_W),
    .INIT_STRIDE(MAXPT), .INIT_IDX(1), .INIT_VAL('0)) u_out_mem (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .we_i(we_i && pt_hit && addr_i[0]),
    .waddr_i(bus_idx),
    .wdata_i(wdata_i),
    .raddr_i(mem_raddr),
    .rdata_o(out_q)
  );

  // ==========================================================
  // Register read
  always_comb
  begin
    reg_rd = '0;
    if (glb_hit)
    begin
      case (addr_i)
        A_GLOBAL: reg_rd[GLB_EN_BIT] = glb_en;
        A_IRQ_ST: reg_rd[NCURVE-1:0] = irq_st;
        A_IRQ_MASK: reg_rd[NCURVE-1:0] = irq_mask;
        A_FLAGS: reg_rd[NCURVE-1:0] = scaling_curve_range_flag_o;
        default: ;
      endcase
    end
    else if (crv_hit)
    begin
      case (addr_i[3:0])
        F_CTRL:
        begin
          reg_rd[CTRL_EN_BIT] = en[bc];
          reg_rd[CTRL_FILT_BIT] = filt_en[bc];
          reg_rd[CTRL_RNG_BIT] = rng_en[bc];
          reg_rd[CTRL_RND_LSB +: 2] = rnd[bc];
          reg_rd[CTRL_SRC_LSB +: SRC_W] = src[bc];
        end
        F_TAU: reg_rd[TAU_W-1:0] = tau[bc];
        F_UPD: reg_rd[UPD_W-1:0] = upd[bc];
        F_MIN: reg_rd = lim_min[bc];
        F_MAX: reg_rd = lim_max[bc];
        F_INPUT: reg_rd = in_val[bc];
        F_OUTPUT: reg_rd = out_val[bc];
        F_USED: reg_rd[USED_W-1:0] = used[bc];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      rd_mem_q <= 1'b0;
      rd_sel_q <= 1'b0;
      reg_rdata_q <= '0;
    end
    else
    begin
      rd_mem_q <= re_i && pt_hit;
      rd_sel_q <= addr_i[0];
      reg_rdata_q <= re_i ? reg_rd : '0;
    end
  end

  assign rdata_o = rd_mem_q ? (rd_sel_q ? out_q : in_q) : reg_rdata_q;

  // ==========================================================
  // Curve selection and sampling
  always_comb
  begin
    pick_ok = 1'b0;
    pick = '0;
    for (int i = NCURVE - 1; i >= 0; i--)
    begin
      if (pending[i])
      begin
        pick_ok = 1'b1;
        pick = 4'(i);
      end
    end
  end

  assign x_new = meas_valid_i[src[pick]] ? meas_i[src[pick]]
                 : raw_last[pick];
  assign pt_used = (pt < 5'h02) || used[cur][pt - 5'h02];

  // ==========================================================
  // Processing engine
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      state <= S_IDLE;
      cur <= '0;
      pt <= '0;
      prev_ok <= 1'b0;
      cur_y <= '0;
      px <= '0;
      py <= '0;
      result <= '0;
      div_start <= 1'b0;
      div_num <= '0;
      div_den <= '0;
    end
    else
    begin
      div_start <= 1'b0;
      case (state)
        S_IDLE:
          if (pick_ok)
          begin
            cur <= pick;
            pt <= '0;
            prev_ok <= 1'b0;
            if (filt_en[pick] && have[pick]
                && {{(TAU_W-UPD_W){1'b0}}, upd[pick]} < tau[pick])
            begin
              div_start <= 1'b1;
              div_num <= (ext(x_new) - ext(in_val[pick]))
                         * ext(VAL_W'(upd[pick]));
              div_den <= VAL_W'(tau[pick]);
              state <= S_FDIV;
            end
            else
            begin
              cur_y <= x_new;
              state <= S_SCAN;
            end
          end
        S_FDIV:
          if (div_done)
          begin
            cur_y <= in_val[cur] + div_q[VAL_W-1:0];
            state <= S_SCAN;
          end
        S_SCAN:
          if (pt == 5'(MAXPT))
          begin
            result <= py;
            state <= S_DONE;
          end
          else if (!pt_used)
            pt <= pt + 5'h01;
          else if (eng_rd_ok)
            state <= S_CHK;
        S_CHK:
          if (cur_y <= in_q)
          begin
            if (!prev_ok || in_q == px)
            begin
              result <= out_q;
              state <= S_DONE;
            end
            else
            begin
              div_start <= 1'b1;
              div_num <= (ext(cur_y) - ext(px)) * (ext(out_q) - ext(py));
              div_den <= in_q - px;
              state <= S_IDIV;
            end
          end
          else
          begin
            px <= in_q;
            py <= out_q;
            prev_ok <= 1'b1;
            pt <= pt + 5'h01;
            state <= S_SCAN;
          end
        S_IDIV:
          if (div_done)
          begin
            result <= py + div_q[VAL_W-1:0];
            state <= S_DONE;
          end
        S_DONE: state <= S_IDLE;
        default: state <= S_IDLE;
      endcase
    end
  end

  // ==========================================================
  // Per-curve results
  always_ff @(posedge clk_i or posedge reset_i)
  begin
    if (reset_i)
    begin
      for (int i = 0; i < NCURVE; i++)
      begin
        in_val[i] <= '0;
        out_val[i] <= '0;
        raw_last[i] <= '0;
      end
      flag <= '0;
      have <= '0;
    end
    else
    begin
      if (state == S_IDLE && pick_ok && meas_valid_i[src[pick]])
        raw_last[pick] <= meas_i[src[pick]];
      if (state == S_DONE)
      begin
        in_val[cur] <= cur_y;
        out_val[cur] <= round_val(result, rnd[cur]);
        flag[cur] <= cur_y < lim_min[cur] || cur_y > lim_max[cur];
        have[cur] <= 1'b1;
      end
    end
  end

  aic_divider #(.NUM_W(NUM_W), .DEN_W(VAL_W)) u_div (
    .clk_i(clk_i),
    .reset_i(reset_i),
    .start_i(div_start),
    .num_i(div_num),
    .den_i(div_den),
    .done_o(div_done),
    .quot_o(div_q)
  );

endmodule

// file: testbench/aic_meas_model.sv
// Behavioural measurement channels feeding the scaling curves
`timescale 1ns/100ps
module aic_meas_model
  import aic_pkg::*;
(
  // Clock
  input wire logic clk_i,
  // Channel outputs
  output logic signed [VAL_W-1:0] meas_o [NSRC],
  output logic [NSRC-1:0] meas_valid_o
);
  logic signed [VAL_W-1:0] last [NSRC];

  initial
  begin
    meas_valid_o = '1;
    for (int i = 0; i < NSRC; i++)
    begin
      last[i] = '0;
      meas_o[i] = '0;
    end
  end

  // ==========================================================
  // Lost channel shows junk; values settle off the sampling edge
  always @(negedge clk_i)
    for (int i = 0; i < NSRC; i++)
      meas_o[i] <= meas_valid_o[i] ? last[i] : ~meas_o[i];

  task automatic put(input int s, input logic signed [VAL_W-1:0] v,
    input logic ok);
    @(posedge clk_i);
    last[s] <= v;
    meas_valid_o[s] <= ok;
  endtask
endmodule

// file: testbench/aic_scaling_curves_chk.sv
// Port assertions for the analog input scaling curves
`timescale 1ns/100ps
module aic_scaling_curves_chk
  import aic_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Register port
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic [VAL_W-1:0] wdata_i,
  input wire logic we_i,
  input wire logic re_i,
  input wire logic [VAL_W-1:0] rdata_o,
  // Measurement channels
  input wire logic signed [VAL_W-1:0] meas_i [NSRC],
  input wire logic [NSRC-1:0] meas_valid_i,
  // Indications
  input wire logic [NCURVE-1:0] scaling_curve_range_flag_o,
  input wire logic irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);

  // ==========================================================
  // Shadow of enables and mask
  logic glb;
  logic crv;
  logic [NCURVE-1:0] mask;
  logic [NCURVE-1:0] en;
  logic [NCURVE-1:0] rng;
  logic [NCURVE-1:0] flg;
  assign flg = scaling_curve_range_flag_o;
  assign crv = we_i && addr_i[11:8] == CRV_PAGE && addr_i[3:0] == F_CTRL
    && addr_i[7:4] < 4'ha;

  always_ff @(posedge clk_i or posedge reset_i)
    if (reset_i)
    begin
      glb <= 1'b0;
      mask <= '0;
      en <= '0;
      rng <= '0;
    end
    else
    begin
      if (we_i && addr_i == A_GLOBAL)
        glb <= wdata_i[GLB_EN_BIT];
      if (we_i && addr_i == A_IRQ_MASK)
        mask <= wdata_i[NCURVE-1:0];
      if (crv)
        en[addr_i[7:4]] <= wdata_i[CTRL_EN_BIT];
      if (crv)
        rng[addr_i[7:4]] <= wdata_i[CTRL_RNG_BIT];
    end

  sequence s_rd(logic [ADDR_W-1:0] a);
    re_i && addr_i == a;
  endsequence

  // ==========================================================
  // Assertions
  a_global_gate: assert property (!glb |-> flg == '0)
    else $error("flag set while scaling is off");
  a_curve_gate: assert property ((flg & ~en) == '0)
    else $error("flag set on a disabled curve");
  a_range_gate: assert property ((flg & ~rng) == '0)
    else $error("flag set without range check");
  a_flag_read: assert property (s_rd(A_FLAGS) |=>
    rdata_o == VAL_W'($past(flg)))
    else $error("flag register differs from flag output");
  a_global_read: assert property (s_rd(A_GLOBAL) |=>
    rdata_o == VAL_W'(glb))
    else $error("global enable readback wrong");
  a_mask_read: assert property (s_rd(A_IRQ_MASK) |=>
    rdata_o == VAL_W'(mask))
    else $error("mask readback wrong");
  a_idle_zero: assert property (!re_i |=> rdata_o == '0)
    else $error("read data not zero when idle");
  a_unmapped_zero: assert property (
    re_i && addr_i inside {[12'h004:12'h0ff]} |=> rdata_o == '0)
    else $error("unmapped read not zero");
  a_irq_masked: assert property (mask == '0 [*2] |-> !irq_o)
    else $error("interrupt with all sources masked");
  a_irq_on_rise: assert property (
    |(flg & ~$past(flg) & mask) |-> ##[0:2] irq_o)
    else $error("no interrupt on unmasked flag rise");
endmodule

// file: testbench/tb_top.sv
// Self-checking testbench for the analog input scaling curves
`timescale 1ns/100ps
module tb_top
  import aic_pkg::*;
;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [VAL_W-1:0] wdata_i = '0;
  logic we_i = 1'b0;
  logic re_i = 1'b0;
  logic [VAL_W-1:0] rdata_o;
  logic signed [VAL_W-1:0] meas [NSRC];
  logic [NSRC-1:0] meas_valid;
  logic [NCURVE-1:0] flag;
  logic irq;
  int err_count = 0;
  int comparisons = 0;

  always #2.5 clk_i = ~clk_i;

  aic_meas_model u_meas (.clk_i, .meas_o(meas), .meas_valid_o(meas_valid));

  aic_scaling_curves #(.TICK_CYCLES(50)) dut (.clk_i, .reset_i, .addr_i,
    .wdata_i, .we_i, .re_i, .rdata_o, .meas_i(meas),
    .meas_valid_i(meas_valid), .scaling_curve_range_flag_o(flag),
    .irq_o(irq));

  // ==========================================================
  // Bus and compare helpers
  function automatic logic [ADDR_W-1:0] cr(input int c, f);
    return ADDR_W'(12'h100 + c * 16 + f);
  endfunction

  function automatic logic [ADDR_W-1:0] pt(input int c, p, s);
    return ADDR_W'(12'h800 + c * 64 + p * 2 + s);
  endfunction

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic check(input logic [VAL_W-1:0] got, exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [VAL_W-1:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    we_i <= 1'b1;
    @(posedge clk_i);
    we_i <= 1'b0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [VAL_W-1:0] v);
    @(posedge clk_i);
    addr_i <= a;
    re_i <= 1'b1;
    @(posedge clk_i);
    re_i <= 1'b0;
    #1;
    v = rdata_o;
  endtask

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [VAL_W-1:0] e);
    logic [VAL_W-1:0] v;
    rd(a, v);
    check(v, e);
  endtask

  // Poll until the result lands, bounded
  task automatic wait_val(input logic [ADDR_W-1:0] a,
    input logic [VAL_W-1:0] e);
    logic [VAL_W-1:0] v;
    for (int i = 0; i < 400; i++)
    begin
      rd(a, v);
      if (v === e)
        break;
    end
    check(v, e);
    if (v !== e)
      final_report();
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_defaults();
    rdc(A_GLOBAL, '0);
    rdc(cr(0, F_CTRL), '0);
    rdc(cr(9, F_TAU), VAL_W'(TAU_DEF));
    rdc(cr(0, F_UPD), VAL_W'(UPD_DEF));
    rdc(cr(0, F_MIN), '0);
    rdc(cr(0, F_MAX), '0);
    rdc(cr(0, F_USED), '0);
    rdc(pt(0, 1, 0), SCALE);
    rdc(pt(0, 1, 1), '0);
    rdc(12'h004, '0);
    $display("Test defaults done");
  endtask

  task automatic t_curve();
    int mv [6] = '{312345, 312345, 312345, 312345, 30000, 30000};
    int rm [6] = '{0, 1, 2, 3, 0, 3};
    int ev [6] = '{2123450, 2100000, 2200000, 2100000, 150000, 200000};
    wr(A_GLOBAL, 40'h1);
    wr(pt(0, 1, 0), 40'd200000);
    wr(pt(0, 1, 1), 40'd1000000);
    wr(pt(0, 2, 0), 40'd400000);
    wr(pt(0, 2, 1), 40'd3000000);
    wr(cr(0, F_USED), 40'h1);
    wr(cr(0, F_UPD), 40'h1);
    for (int i = 0; i < 6; i++)
    begin
      u_meas.put(3, VAL_W'(mv[i]), 1'b1);
      wr(cr(0, F_CTRL), 40'h301 | VAL_W'(rm[i]) << 4);
      wait_val(cr(0, F_OUTPUT), VAL_W'(ev[i]));
    end
    rdc(cr(0, F_INPUT), 40'd30000);
    wr(cr(0, F_USED), 40'h0);
    u_meas.put(3, 40'd312345, 1'b1);
    wait_val(cr(0, F_OUTPUT), 40'd1000000);
    rdc(cr(1, F_INPUT), '0);
    $display("Test curve done");
  endtask

  task automatic t_range();
    wr(cr(0, F_MIN), 40'd100000);
    wr(cr(0, F_MAX), 40'd200000);
    wr(A_IRQ_MASK, 40'h1);
    wr(cr(0, F_CTRL), 40'h305);
    wait_val(A_FLAGS, 40'h1);
    check(VAL_W'(flag), 40'h1);
    check(VAL_W'(irq), 40'h1);
    wr(A_IRQ_ST, 40'h1);
    #1;
    check(VAL_W'(irq), 40'h0);
    u_meas.put(3, 40'd150000, 1'b1);
    wait_val(A_FLAGS, 40'h0);
    u_meas.put(3, 40'd50000, 1'b1);
    wait_val(A_FLAGS, 40'h1);
    wr(A_GLOBAL, 40'h0);
    rdc(A_FLAGS, '0);
    wr(A_GLOBAL, 40'h1);
    wr(cr(0, F_CTRL), 40'h301);
    rdc(A_FLAGS, '0);
    wr(A_IRQ_MASK, 40'h0);
    wr(A_IRQ_ST, 40'h1);
    #1;
    check(VAL_W'(irq), 40'h0);
    $display("Test range done");
  endtask

  task automatic t_lost_filter();
    u_meas.put(3, 40'd150000, 1'b1);
    wait_val(cr(0, F_INPUT), 40'd150000);
    u_meas.put(3, 40'd987654, 1'b0);
    repeat (300) @(posedge clk_i);
    rdc(cr(0, F_INPUT), 40'd150000);
    u_meas.put(3, 40'd400000, 1'b1);
    wr(cr(0, F_TAU), 40'h1);
    wr(cr(0, F_CTRL), 40'h303);
    wait_val(cr(0, F_INPUT), 40'd400000);
    wr(cr(0, F_TAU), 40'h4);
    u_meas.put(3, 40'd800000, 1'b1);
    wait_val(cr(0, F_INPUT), 40'd500000);
    wait_val(cr(0, F_INPUT), 40'd575000);
    $display("Test lost and filter done");
  endtask

  initial
  begin
    repeat (2) @(posedge clk_i);
    reset_i <= 1'b0;
    t_defaults();
    t_curve();
    t_range();
    t_lost_filter();
    final_report();
  end
endmodule

bind aic_scaling_curves aic_scaling_curves_chk u_chk (.clk_i, .reset_i,
  .addr_i, .wdata_i, .we_i, .re_i, .rdata_o, .meas_i, .meas_valid_i,
  .scaling_curve_range_flag_o, .irq_o);
